/* File: include/hpr_regs.svh */
/*
 Constants of the host port and reset control block: address map, sizes,
 reset values and timing counts. Assumes a 20 MHz system clock.
*/
// Function
// - Accesses start only while chip select is low; high select is ignored.
// - Strobe and select must both be low to start a read or write.
// - Read/write picks bus direction; device drives data only on reads.
// - Acknowledge is driven low when a transfer completes, otherwise released.
// - Data moves over a sixteen bit two-way data bus.
// - A twelve bit address selects the register or memory word.
// - During reset stream drivers are off and impedance controls high.
// - Reset clears every register and internal counter.
// - Registers and connection memory read/write; data memory is read only.
// - Port control uses select, strobe, read/write and acknowledge only.
`ifndef HPR_REGS_SVH
`define HPR_REGS_SVH

// ==========================================================================
// Bus widths and storage sizes
`define HPR_AW 12
`define HPR_DW 16
`define HPR_NSTREAM 16
`define HPR_NREG 8
`define HPR_NCM 32
`define HPR_NDM 32
`define HPR_REG_IW 3
`define HPR_MEM_IW 5

// ==========================================================================
// Address regions, taken from address bits 11:10
`define HPR_RGN_HI 11
`define HPR_RGN_LO 10
`define HPR_RGN_REG 2'h0
`define HPR_RGN_DM 2'h1

// ==========================================================================
// Reset values
`define HPR_WORD_RST 16'h0000
`define HPR_STREAM_OFF 16'h0000
`define HPR_HIZ_HIGH 16'hffff

// ==========================================================================
// Timing
`define HPR_CLK_NS 50
`define HPR_SETTLE_US 600
`define HPR_SETTLE_CYC ((`HPR_SETTLE_US * 1000) / `HPR_CLK_NS)
`define HPR_CNT_W 14
`define HPR_RESET_US 1000
`define HPR_RESET_CYC ((`HPR_RESET_US * 1000) / `HPR_CLK_NS)

`endif

/* File: include/hpr_pkg.sv */
/*
 Types of the host port and reset control block.
 Assumes hpr_regs.svh is on the include path.
*/
`include "hpr_regs.svh"

package hpr_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_ACK
   } hpr_fsm_t;

   // Synchronised view of the host pins
   typedef struct packed {
      logic cs_n;
      logic strobe_n;
      logic rw;
      logic [`HPR_AW-1:0] addr;
      logic [`HPR_DW-1:0] wdata;
   } hpr_bus_t;

   // Whole state of the port
   typedef struct packed {
      hpr_fsm_t fsm;
      logic [`HPR_NREG-1:0][`HPR_DW-1:0] regs;
      logic [`HPR_NCM-1:0][`HPR_DW-1:0] cm;
      logic [`HPR_NDM-1:0][`HPR_DW-1:0] dm;
      logic [`HPR_DW-1:0] rdata;
      logic data_oe;
      logic ack_n;
      logic ack_oe;
      logic [`HPR_NSTREAM-1:0] stream_oe;
      logic [`HPR_NSTREAM-1:0] hiz;
      logic [`HPR_CNT_W-1:0] settle_cnt;
      logic settle_done;
   } hpr_core_t;

endpackage

/* File: verilog/hpr_sync.sv */
/*
 Two flip-flop synchroniser for a group of pin inputs.
 Assumes the inputs are quasi-static around each strobe edge.
*/
`timescale 1ns/1ps
`default_nettype none

module hpr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // ========================================================================
   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '1;
         q <= '1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

`default_nettype wire

/* File: verilog/hpr_port.sv */
/*
 Asynchronous microprocessor port with register bank, connection memory,
 read-only data memory, and reset control of the stream output pins.
 Assumes host pins are asynchronous and held stable through a transfer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpr_regs.svh"

module hpr_port
   import hpr_pkg::*;
#(
   parameter logic [`HPR_CNT_W-1:0] SETTLE_CYC = `HPR_CNT_W'(`HPR_SETTLE_CYC)
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Host control pins
   input wire logic chip_select_n,
   input wire logic data_strobe_n,
   input wire logic read_write,
   input wire logic [`HPR_AW-1:0] host_address_bus,
   // Host data bus, split
   input wire logic [`HPR_DW-1:0] host_data_bus_i,
   output logic [`HPR_DW-1:0] host_data_bus_o,
   output logic host_data_bus_oe,
   // Transfer acknowledge, three-state
   output logic transfer_ack_n_o,
   output logic transfer_ack_n_oe,
   // Switch core side
   input wire logic dm_wr_en,
   input wire logic [`HPR_MEM_IW-1:0] dm_wr_idx,
   input wire logic [`HPR_DW-1:0] dm_wr_data,
   input wire logic [`HPR_NSTREAM-1:0] stream_oe_req,
   input wire logic [`HPR_NSTREAM-1:0] hiz_req,
   output logic [`HPR_NREG-1:0][`HPR_DW-1:0] cfg_regs,
   output logic [`HPR_NCM-1:0][`HPR_DW-1:0] conn_mem,
   // Stream pin controls
   output logic [`HPR_NSTREAM-1:0] serial_out_streams_oe,
   output logic [`HPR_NSTREAM-1:0] output_hiz_ctrl,
   output logic settle_done
);

   hpr_bus_t bus_raw;
   hpr_bus_t bus_s;
   hpr_core_t cur_r;
   hpr_core_t cur_nxt;
   logic [1:0] rgn;
   logic sel;

   assign bus_raw = '{cs_n: chip_select_n, strobe_n: data_strobe_n, rw: read_write,
                      addr: host_address_bus, wdata: host_data_bus_i};

   // ========================================================================
   // Pin synchronisers
   hpr_sync #(.W($bits(hpr_bus_t))) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(bus_raw),
      .q(bus_s)
   );

   assign rgn = bus_s.addr[`HPR_RGN_HI:`HPR_RGN_LO];
   assign sel = !bus_s.cs_n && !bus_s.strobe_n;

   // ========================================================================
   // Next state
   always_comb begin
      cur_nxt = cur_r;
      // Core side data memory fill
      if (dm_wr_en) begin
         cur_nxt.dm[dm_wr_idx] = dm_wr_data;
      end
      // Settle counter; host must not access before it ends
      if (!cur_r.settle_done) begin
         if (cur_r.settle_cnt >= SETTLE_CYC - `HPR_CNT_W'(1)) begin
            cur_nxt.settle_done = 1'b1;
         end else begin
            cur_nxt.settle_cnt = cur_r.settle_cnt + `HPR_CNT_W'(1);
         end
      end
      cur_nxt.stream_oe = stream_oe_req;
      cur_nxt.hiz = hiz_req;
      case (cur_r.fsm)
         ST_IDLE: begin
            if (sel) begin
               cur_nxt.fsm = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            // Read when high, write when low
            if (bus_s.rw) begin
               if (rgn == `HPR_RGN_REG) begin
                  cur_nxt.rdata = cur_r.regs[bus_s.addr[`HPR_REG_IW-1:0]];
               end else if (rgn == `HPR_RGN_DM) begin
                  cur_nxt.rdata = cur_r.dm[bus_s.addr[`HPR_MEM_IW-1:0]];
               end else begin
                  cur_nxt.rdata = cur_r.cm[bus_s.addr[`HPR_MEM_IW-1:0]];
               end
               cur_nxt.data_oe = 1'b1;
            end else begin
               // Data memory writes are acked but dropped
               if (rgn == `HPR_RGN_REG) begin
                  cur_nxt.regs[bus_s.addr[`HPR_REG_IW-1:0]] = bus_s.wdata;
               end else if (rgn != `HPR_RGN_DM) begin
                  cur_nxt.cm[bus_s.addr[`HPR_MEM_IW-1:0]] = bus_s.wdata;
               end
            end
            cur_nxt.ack_n = 1'b0;
            cur_nxt.ack_oe = 1'b1;
            cur_nxt.fsm = ST_ACK;
         end
         ST_ACK: begin
            // Hold until host lets go of strobe or select
            if (!sel) begin
               cur_nxt.ack_n = 1'b1;
               cur_nxt.ack_oe = 1'b0;
               cur_nxt.data_oe = 1'b0;
               cur_nxt.fsm = ST_IDLE;
            end
         end
         default: begin
            cur_nxt.fsm = ST_IDLE;
         end
      endcase
   end

   // ========================================================================
   // State register; reset clears everything but ack_n and hiz, which it sets high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_r <= '0;
         cur_r.fsm <= ST_IDLE;
         cur_r.ack_n <= 1'b1;
         cur_r.stream_oe <= `HPR_STREAM_OFF;
         cur_r.hiz <= `HPR_HIZ_HIGH;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // ========================================================================
   // Outputs
   assign host_data_bus_o = cur_r.rdata;
   assign host_data_bus_oe = cur_r.data_oe;
   assign transfer_ack_n_o = cur_r.ack_n;
   assign transfer_ack_n_oe = cur_r.ack_oe;
   assign cfg_regs = cur_r.regs;
   assign conn_mem = cur_r.cm;
   assign serial_out_streams_oe = cur_r.stream_oe;
   assign output_hiz_ctrl = cur_r.hiz;
   assign settle_done = cur_r.settle_done;

   // ========================================================================
   // Checks
   property p_cs_ignored;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_IDLE && bus_s.cs_n) |=> (cur_r.fsm == ST_IDLE && !cur_r.ack_oe);
   endproperty
   a_cs_ignored: assert property (p_cs_ignored)
      else $error("access taken without select");

   property p_strobe_needed;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_IDLE && !bus_s.cs_n && bus_s.strobe_n) |=> cur_r.fsm == ST_IDLE;
   endproperty
   a_strobe_needed: assert property (p_strobe_needed)
      else $error("access taken without strobe");

   property p_drive_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_ACCESS && !bus_s.rw) |=> !cur_r.data_oe;
   endproperty
   a_drive_read: assert property (p_drive_read)
      else $error("data driven on write");

   property p_ack_timing;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_IDLE && sel) |=> ##1 (cur_r.ack_oe && !cur_r.ack_n);
   endproperty
   a_ack_timing: assert property (p_ack_timing)
      else $error("ack not given two cycles on");

   property p_reg_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_ACCESS && bus_s.rw && rgn == `HPR_RGN_REG)
      |=> cur_r.rdata == $past(cur_r.regs[bus_s.addr[`HPR_REG_IW-1:0]]);
   endproperty
   a_reg_read: assert property (p_reg_read)
      else $error("wrong register read data");

   property p_cm_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_ACCESS && !bus_s.rw && bus_s.addr[`HPR_RGN_HI])
      |=> cur_r.cm[$past(bus_s.addr[`HPR_MEM_IW-1:0])] == $past(bus_s.wdata);
   endproperty
   a_cm_write: assert property (p_cm_write)
      else $error("connection memory write lost");

   property p_dm_ro;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_ACCESS && !bus_s.rw && rgn == `HPR_RGN_DM && !dm_wr_en)
      |=> $stable(cur_r.dm);
   endproperty
   a_dm_ro: assert property (p_dm_ro)
      else $error("data memory written from port");

   property p_ack_release;
      @(posedge clk_sys) disable iff (!rst_n)
      (cur_r.fsm == ST_ACK && !sel) |=> (!cur_r.ack_oe && !cur_r.data_oe) ##1 !cur_r.ack_oe;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("ack not released");

   property p_settle;
      @(posedge clk_sys) disable iff (!rst_n)
      cur_r.settle_done |=> cur_r.settle_done && $stable(cur_r.settle_cnt);
   endproperty
   a_settle: assert property (p_settle)
      else $error("settle flag dropped");

endmodule

`default_nettype wire

/* File: dv/hpr_host_model.sv */
/*
 Bus master model of the host port: select, strobe, direction, address, data.
 Assumes the bench resolves the acknowledge and data pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpr_regs.svh"

module hpr_host_model (
   // Clock
   input wire logic clk_sys,
   // Resolved pins
   input wire logic ack_pin_n,
   input wire logic [`HPR_DW-1:0] data_pin,
   // Host drive
   output logic cs_n,
   output logic data_strobe_n,
   output logic rw,
   output logic [`HPR_AW-1:0] addr,
   output logic [`HPR_DW-1:0] wdata,
   output logic wdata_oe
);
   initial begin
      cs_n = 1'b1;
      data_strobe_n = 1'b1;
      rw = 1'b1;
      addr = 12'h000;
      wdata = 16'h0000;
      wdata_oe = 1'b0;
   end

   // ==========================================================
   // One word transfer; ok low if no acknowledge came
   task automatic access(input logic rd, input logic [`HPR_AW-1:0] a,
      input logic [`HPR_DW-1:0] wd, output logic [`HPR_DW-1:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 16'h0000;
      @(posedge clk_sys);
      rw <= rd;
      addr <= a;
      wdata <= wd;
      wdata_oe <= ~rd;
      cs_n <= 1'b0;
      data_strobe_n <= 1'b0;
      for (n = 0; n < 12 && !ok; n++) begin
         @(posedge clk_sys);
         if (ack_pin_n === 1'b0) begin
            ok = 1'b1;
            q = data_pin;
         end
      end
      // Held until acknowledge or 12 cycles; released lines show inverted values
      cs_n <= 1'b1;
      data_strobe_n <= 1'b1;
      wdata_oe <= 1'b0;
      addr <= ~a;
      wdata <= ~wd;
      repeat (6) @(posedge clk_sys);
   endtask

   // ==========================================================
   // Half a select; counts acknowledges seen
   task automatic probe(input logic c, input logic d, output int seen);
      seen = 0;
      @(posedge clk_sys);
      cs_n <= c;
      data_strobe_n <= d;
      repeat (10) begin
         @(posedge clk_sys);
         if (ack_pin_n !== 1'b1) seen++;
      end
      cs_n <= 1'b1;
      data_strobe_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_host_port_and_reset_control.sv */
/*
 Self-checking bench of the host port and reset control block.
 Assumes a pull-up on acknowledge and a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpr_regs.svh"

module tb_host_port_and_reset_control
   import hpr_pkg::*;
;
   logic clk_sys, rst_n, cs_n, data_strobe_n, rw, wd_oe, dm_wr_en;
   logic ack_o, ack_oe, d_oe, settle_done;
   logic [11:0] addr;
   logic [15:0] wd, d_o, data_pin, dm_wr_data, oe_req, hiz_req, st_oe, hiz;
   logic [4:0] dm_wr_idx;
   logic [7:0][15:0] cfg_regs;
   logic [31:0][15:0] conn_mem;
   wire ack_pin_n = ack_oe ? ack_o : 1'b1;
   int err_total = 0, checks_done = 0, cyc = 0;
   // Undriven bus shows inverse of the last host value
   assign data_pin = d_oe ? d_o : (wd_oe ? wd : ~wd);
   // Both sides on the data pins at once
   logic clash_r = 1'b0;
   always @(posedge clk_sys) begin
      if (d_oe && wd_oe) begin
         clash_r <= 1'b1;
      end
   end

   hpr_port #(.SETTLE_CYC(14'h14)) hpr_port_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .chip_select_n(cs_n), .data_strobe_n(data_strobe_n), .read_write(rw),
      .host_address_bus(addr), .host_data_bus_i(data_pin), .host_data_bus_o(d_o),
      .host_data_bus_oe(d_oe), .transfer_ack_n_o(ack_o), .transfer_ack_n_oe(ack_oe),
      .dm_wr_en(dm_wr_en), .dm_wr_idx(dm_wr_idx), .dm_wr_data(dm_wr_data),
      .stream_oe_req(oe_req), .hiz_req(hiz_req), .cfg_regs(cfg_regs),
      .conn_mem(conn_mem), .serial_out_streams_oe(st_oe), .output_hiz_ctrl(hiz),
      .settle_done(settle_done));
   hpr_host_model hpr_host_model_i (.clk_sys(clk_sys), .ack_pin_n(ack_pin_n),
      .data_pin(data_pin), .cs_n(cs_n), .data_strobe_n(data_strobe_n), .rw(rw), .addr(addr),
      .wdata(wd), .wdata_oe(wd_oe));

   // ==========================================================
   // Clock, timeout, report
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      // Long mid-run reset dominates the run
      if (cyc == 25000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset(input int hold);
      int n;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      oe_req <= 16'hffff;
      hiz_req <= 16'h0000;
      repeat (hold) @(posedge clk_sys);
      check("stream_oe", st_oe, 16'h0000);
      check("hiz", hiz, 16'hffff);
      check("data_oe", 16'(d_oe), 16'h0000);
      check("ack_oe", 16'(ack_oe), 16'h0000);
      check("reg7", cfg_regs[7], 16'h0000);
      check("cm31", conn_mem[31], 16'h0000);
      check("settle", 16'(settle_done), 16'h0000);
      rst_n <= 1'b1;
      // Settle wait before any access
      for (n = 0; n < 40 && settle_done !== 1'b1; n++) @(posedge clk_sys);
      check("settle", 16'(settle_done), 16'h0001);
      check("stream_oe run", st_oe, 16'hffff);
      check("hiz run", hiz, 16'h0000);
   endtask
   task automatic t_rw();
      logic [15:0] q;
      logic ok;
      hpr_host_model_i.access(1'b0, 12'h007, 16'ha5c3, q, ok);
      check("reg ack", 16'(ok), 16'h0001);
      hpr_host_model_i.access(1'b0, 12'h81f, 16'h3c96, q, ok);
      check("reg7", cfg_regs[7], 16'ha5c3);
      check("cm31", conn_mem[31], 16'h3c96);
      hpr_host_model_i.access(1'b1, 12'h007, 16'h0000, q, ok);
      check("reg rd", q, 16'ha5c3);
      hpr_host_model_i.access(1'b1, 12'h81f, 16'h0000, q, ok);
      check("cm rd", q, 16'h3c96);
      check("data clash", 16'(clash_r), 16'h0000);
   endtask
   task automatic t_dm();
      logic [15:0] q;
      logic ok;
      @(posedge clk_sys);
      dm_wr_en <= 1'b1;
      dm_wr_idx <= 5'h05;
      dm_wr_data <= 16'h1234;
      @(posedge clk_sys);
      dm_wr_en <= 1'b0;
      hpr_host_model_i.access(1'b0, 12'h405, 16'hffff, q, ok);
      check("dm wr ack", 16'(ok), 16'h0001);
      hpr_host_model_i.access(1'b1, 12'h405, 16'h0000, q, ok);
      check("dm rd", q, 16'h1234);
      check("dm clash", 16'(clash_r), 16'h0000);
   endtask
   task automatic t_cleared();
      logic [15:0] q;
      logic ok;
      hpr_host_model_i.access(1'b1, 12'h405, 16'h0000, q, ok);
      check("dm cleared", q, 16'h0000);
   endtask
   task automatic t_refuse();
      int s;
      hpr_host_model_i.probe(1'b1, 1'b0, s);
      check("no sel", 16'(s), 16'h0000);
      hpr_host_model_i.probe(1'b0, 1'b1, s);
      check("no strobe", 16'(s), 16'h0000);
   endtask

   initial begin
      rst_n = 1'b0;
      dm_wr_en = 1'b0;
      dm_wr_idx = 5'h00;
      dm_wr_data = 16'h0000;
      oe_req = 16'h0000;
      hiz_req = 16'hffff;
      t_reset(2);
      t_rw();
      t_dm();
      t_refuse();
      // Second reset must clear what was written
      t_reset(`HPR_RESET_CYC + 1);
      t_cleared();
      end_of_test();
   end
endmodule
`default_nettype wire
